// File: verilog/cpio_pkg.sv
// constants shared by the channel pulse i/o register block
package cpio_pkg;
   // channel and input counts
   localparam int CH_N = 11;
   localparam int IN_N = 2 * CH_N;
   localparam logic [15:0] PAIR_LEN = 16'h002c;
   localparam logic [15:0] WT_LEN = 16'h0016;
   // protocol addresses (register number minus one)
   localparam logic [15:0] A_LVL1 = 16'h0078;
   localparam logic [15:0] A_LVL2 = 16'h0079;
   localparam logic [15:0] A_OPEN = 16'h0082;
   localparam logic [15:0] A_CLOSE = 16'h0083;
   localparam logic [15:0] A_DEACT = 16'h0084;
   localparam logic [15:0] A_ACT = 16'h0085;
   localparam logic [15:0] A_FLOW = 16'h36b0;
   localparam logic [15:0] A_CONS = 16'h36e2;
   localparam logic [15:0] A_OPC = 16'h3714;
   localparam logic [15:0] A_PCNT = 16'h3800;
   localparam logic [15:0] A_WT = 16'h3840;
   // field layout of channel bitmaps
   localparam logic [15:0] MAP_MASK = 16'h07ff;
   // reset values
   localparam logic [15:0] MAP_RST = 16'h0000;
   localparam logic [31:0] CNT_RST = 32'h0000_0000;
   localparam logic [15:0] WT_RST = 16'h000a;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
   localparam int MIN_WAIT_S = 5;
   localparam logic [31:0] MIN_WAIT_MS = 32'(MIN_WAIT_S * 1000);
   localparam int IDLE_H = 24;
   localparam logic [31:0] IDLE_MS = 32'(IDLE_H * 3600 * 1000);
   localparam int SEC_PER_H = 3600;
   localparam logic [39:0] FLOW_K = 40'(SEC_PER_H * 1000);
   localparam int DIV_W = 40;
   // flow divider scheduler
   typedef enum logic [1:0] {
      CPIO_IDLE = 2'b00,
      CPIO_BUSY = 2'b01,
      CPIO_STORE = 2'b11
   } cpio_sched_t;
endpackage

// File: verilog/cpio_div.sv
// serial restoring divider used for the flow computation
`timescale 1ns/100ps
module cpio_div
   import cpio_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // request
   input wire logic start,
   input wire logic [DIV_W-1:0] num,
   input wire logic [31:0] den,
   // answer
   output logic busy,
   output logic done,
   output logic [DIV_W-1:0] quo
);
   logic [32:0] rem_r;
   logic [DIV_W-1:0] q_r;
   logic [5:0] cnt_r;
   logic [31:0] den_r;
   logic busy_r;
   logic done_r;
   wire [32:0] shifted = {rem_r[31:0], q_r[DIV_W-1]};
   wire [32:0] trial = shifted - {1'b0, den_r};
   wire fits = ~trial[32];

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rem_r <= '0;
         q_r <= '0;
         cnt_r <= '0;
         den_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         if (start && !busy_r)
         begin
            rem_r <= '0;
            q_r <= num;
            den_r <= den;
            cnt_r <= 6'(DIV_W);
            busy_r <= 1'b1;
         end
         else if (busy_r)
         begin
            rem_r <= fits ? trial : shifted;
            q_r <= {q_r[DIV_W-2:0], fits};
            cnt_r <= cnt_r - 6'h01;
            if (cnt_r == 6'h01)
            begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end
         end
      end
   end

   assign busy = busy_r;
   assign done = done_r;
   assign quo = q_r;
endmodule // cpio_div

// File: verilog/cpio_regs.sv
// channel pulse i/o register bank: levels, orders, flow, counters
//
// Behaviour
// - first and second input levels shown in two read-only bitmaps, reset zero.
// - bitmap bits 0..10 map to channels 1..11; bits 11..15 unused.
// - status bit reads 1 with input current, 0 without.
// - four read-write order bitmaps open, close, deactivate, activate, reset zero.
// - client writes 1 per channel bit; every set bit is acted upon.
// - accepted order bit clears to 0; stays set with no product connected.
// - both bits of an order pair set gives no equipment action.
// - flow equals 3600 times pulse weight over seconds between last pulses.
// - flow is a read-only 32-bit float pair per input at fixed addresses.
// - pulse weight defaults to 10 and is writable.
// - flow clears after three last intervals without pulse, at least five seconds.
// - flow clears after 24 hours without any pulse.
// - flow clears while the field supply monitor reports loss.
// - pulses counted correctly up to 17 hertz.
// - consumption equals pulse count times pulse weight.
// - consumption is a read-only unsigned 32-bit pair per input, reset zero.
// - client may preset pulse count; counting continues from written value.
// - read-write 32-bit operation counter per input counts falls 1 to 0.
// - protocol address is register number minus one, from zero.
`timescale 1ns/100ps
module cpio_regs
   import cpio_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port, protocol word addresses
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_ack,
   output logic reg_err,
   // field pins, asynchronous
   input wire logic [CH_N-1:0] first_input,
   input wire logic [CH_N-1:0] second_input,
   input wire logic [CH_N-1:0] product_present,
   input wire logic supply_fail,
   // order pulses to channel outputs
   output logic [CH_N-1:0] open_cmd,
   output logic [CH_N-1:0] close_cmd,
   output logic [CH_N-1:0] deactivate_cmd,
   output logic [CH_N-1:0] activate_cmd
);
   function automatic logic [15:0] off(input logic [15:0] a,
                                       input logic [15:0] base);
      return a - base;
   endfunction

   function automatic logic [15:0] word_of(input logic [31:0] v,
                                           input logic lo);
      return lo ? v[15:0] : v[31:16];
   endfunction

   function automatic logic [31:0] put_word(input logic [31:0] v,
                                            input logic lo,
                                            input logic [15:0] w);
      return lo ? {v[31:16], w} : {w, v[15:0]};
   endfunction

   // truncating integer to float32, no rounding
   function automatic logic [31:0] to_f32(input logic [31:0] v);
      logic [4:0] p;
      logic [31:0] m;
      p = 5'h00;
      m = 32'h0000_0000;
      for (int b = 0; b < 32; b++)
         if (v[b])
            p = 5'(b);
      m = v << (5'h1f - p);
      if (v == 32'h0000_0000)
         return 32'h0000_0000;
      return {1'b0, 8'(8'h7f + {3'h0, p}), m[30:8]};
   endfunction

   function automatic logic [31:0] wait_ms(input logic [31:0] ival);
      logic [33:0] t;
      t = 34'(ival) * 34'h3;
      if (t < {2'b00, MIN_WAIT_MS})
         return MIN_WAIT_MS;
      if (t[33:32] != 2'b00)
         return 32'hffff_ffff;
      return t[31:0];
   endfunction

   // input synchronisers; sync1 feeds only sync2
   logic [IN_N:0] sync1_r;
   logic [IN_N:0] sync2_r;
   logic [IN_N-1:0] lvl_r;
   wire [IN_N-1:0] pin_now = sync2_r[IN_N-1:0];
   wire supply_lost = sync2_r[IN_N];
   wire [IN_N-1:0] rise = pin_now & ~lvl_r;
   wire [IN_N-1:0] fall = ~pin_now & lvl_r;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
         lvl_r <= '0;
      end
      else
      begin
         sync1_r <= {supply_fail, second_input, first_input};
         sync2_r <= sync1_r;
         lvl_r <= pin_now;
      end
   end

   // millisecond tick
   logic [31:0] tick_cnt_r;
   logic tick_r;
   always_ff @(posedge mclk)
   begin
      if (rst || tick_cnt_r == 32'(TICK_CYCLES - 1))
         tick_cnt_r <= '0;
      else
         tick_cnt_r <= tick_cnt_r + 32'h1;
      tick_r <= !rst && tick_cnt_r == 32'(TICK_CYCLES - 1);
   end

   // address decode
   wire [15:0] d_flow = off(reg_addr, A_FLOW);
   wire [15:0] d_cons = off(reg_addr, A_CONS);
   wire [15:0] d_opc = off(reg_addr, A_OPC);
   wire [15:0] d_pcnt = off(reg_addr, A_PCNT);
   wire [15:0] d_wt = off(reg_addr, A_WT);
   wire hit_flow = d_flow < PAIR_LEN;
   wire hit_cons = d_cons < PAIR_LEN;
   wire hit_opc = d_opc < PAIR_LEN;
   wire hit_pcnt = d_pcnt < PAIR_LEN;
   wire hit_wt = d_wt < WT_LEN;
   wire hit_lvl1 = reg_addr == A_LVL1;
   wire hit_lvl2 = reg_addr == A_LVL2;
   wire hit_open = reg_addr == A_OPEN;
   wire hit_close = reg_addr == A_CLOSE;
   wire hit_deact = reg_addr == A_DEACT;
   wire hit_act = reg_addr == A_ACT;
   wire hit_ord = hit_open | hit_close | hit_deact | hit_act;
   wire hit_ro = hit_lvl1 | hit_lvl2 | hit_flow | hit_cons;
   wire hit_rw = hit_ord | hit_opc | hit_pcnt | hit_wt;
   // first word of a pair holds the high half
   wire [4:0] i_flow = d_flow[5:1];
   wire [4:0] i_cons = d_cons[5:1];
   wire [4:0] i_opc = d_opc[5:1];
   wire [4:0] i_pcnt = d_pcnt[5:1];
   wire [4:0] i_wt = d_wt[4:0];

   // order bitmaps
   logic [CH_N-1:0] open_r;
   logic [CH_N-1:0] close_r;
   logic [CH_N-1:0] deact_r;
   logic [CH_N-1:0] act_r;
   wire [CH_N-1:0] wbits = reg_wdata[CH_N-1:0];
   wire [CH_N-1:0] oc_both = open_r & close_r;
   wire [CH_N-1:0] da_both = deact_r & act_r;
   wire [CH_N-1:0] fire_open = open_r & ~close_r & product_present;
   wire [CH_N-1:0] fire_close = close_r & ~open_r & product_present;
   wire [CH_N-1:0] fire_deact = deact_r & ~act_r & product_present;
   wire [CH_N-1:0] fire_act = act_r & ~deact_r & product_present;
   // conflicting pair is dropped without a pulse
   wire [CH_N-1:0] oc_take = (open_r | close_r) & product_present;
   wire [CH_N-1:0] da_take = (deact_r | act_r) & product_present;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         open_r <= MAP_RST[CH_N-1:0];
         close_r <= MAP_RST[CH_N-1:0];
         deact_r <= MAP_RST[CH_N-1:0];
         act_r <= MAP_RST[CH_N-1:0];
      end
      else
      begin
         // a write in the clearing cycle stands, so no order is lost
         open_r <= (reg_wr && hit_open) ? wbits : open_r & ~oc_take;
         close_r <= (reg_wr && hit_close) ? wbits : close_r & ~oc_take;
         deact_r <= (reg_wr && hit_deact) ? wbits : deact_r & ~da_take;
         act_r <= (reg_wr && hit_act) ? wbits : act_r & ~da_take;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         open_cmd <= '0;
         close_cmd <= '0;
         deactivate_cmd <= '0;
         activate_cmd <= '0;
      end
      else
      begin
         open_cmd <= fire_open & ~oc_both;
         close_cmd <= fire_close & ~oc_both;
         deactivate_cmd <= fire_deact & ~da_both;
         activate_cmd <= fire_act & ~da_both;
      end
   end

   // per-input memories, index 0..10 first input, 11..21 second input
   logic [31:0] flow_r [IN_N];
   logic [31:0] pcnt_r [IN_N];
   logic [31:0] opc_r [IN_N];
   logic [31:0] since_r [IN_N];
   logic [31:0] ival_r [IN_N];
   logic [15:0] wt_r [IN_N];
   logic [IN_N-1:0] seen_r;
   logic [IN_N-1:0] pend_r;

   // flow divider scheduling
   cpio_sched_t st_r;
   logic [4:0] cur_r;
   logic div_start_r;
   logic [DIV_W-1:0] div_num_r;
   logic [31:0] div_den_r;
   logic div_busy;
   logic div_done;
   logic [DIV_W-1:0] div_quo;
   logic [4:0] pick;
   always_comb
   begin
      pick = 5'h00;
      for (int i = IN_N - 1; i >= 0; i--)
         if (pend_r[i])
            pick = 5'(i);
   end
   wire [31:0] quo_sat = (div_quo[DIV_W-1:32] != '0) ? 32'hffff_ffff
                                                       : div_quo[31:0];
   wire store_flow = st_r == CPIO_STORE;

   cpio_div u_div (
      .mclk(mclk),
      .rst(rst),
      .start(div_start_r),
      .num(div_num_r),
      .den(div_den_r),
      .busy(div_busy),
      .done(div_done),
      .quo(div_quo)
   );

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_r <= CPIO_IDLE;
         cur_r <= '0;
         div_start_r <= 1'b0;
         div_num_r <= '0;
         div_den_r <= '0;
      end
      else
      begin
         div_start_r <= 1'b0;
         case (st_r)
            CPIO_IDLE:
               if (pend_r != '0 && !div_busy)
               begin
                  cur_r <= pick;
                  // ms interval, so scale by 3600 s and 1000 ms
                  div_num_r <= 40'(wt_r[pick]) * FLOW_K;
                  div_den_r <= ival_r[pick];
                  div_start_r <= 1'b1;
                  st_r <= CPIO_BUSY;
               end
            CPIO_BUSY:
               if (div_done)
                  st_r <= CPIO_STORE;
            CPIO_STORE:
               st_r <= CPIO_IDLE;
            default:
               st_r <= CPIO_IDLE;
         endcase
      end
   end

   // counters, timers and flow values
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         seen_r <= '0;
         pend_r <= '0;
         for (int i = 0; i < IN_N; i++)
         begin
            flow_r[i] <= CNT_RST;
            pcnt_r[i] <= CNT_RST;
            opc_r[i] <= CNT_RST;
            since_r[i] <= CNT_RST;
            ival_r[i] <= CNT_RST;
            wt_r[i] <= WT_RST;
         end
      end
      else
      begin
         for (int i = 0; i < IN_N; i++)
         begin
            if (tick_r && since_r[i] < IDLE_MS)
               since_r[i] <= since_r[i] + 32'h1;
            if (store_flow && cur_r == 5'(i))
            begin
               flow_r[i] <= to_f32(quo_sat);
               pend_r[i] <= 1'b0;
            end
            if (rise[i])
            begin
               pcnt_r[i] <= pcnt_r[i] + 32'h1;
               since_r[i] <= '0;
               seen_r[i] <= 1'b1;
               if (seen_r[i] && since_r[i] != '0)
               begin
                  ival_r[i] <= since_r[i];
                  pend_r[i] <= 1'b1;
               end
            end
            else if (seen_r[i] && since_r[i] >= wait_ms(ival_r[i]))
               flow_r[i] <= '0;
            if (since_r[i] >= IDLE_MS)
            begin
               flow_r[i] <= '0;
               // a pulse in the expiry cycle still arms the input
               seen_r[i] <= rise[i];
            end
            if (fall[i])
               opc_r[i] <= opc_r[i] + 32'h1;
            if (reg_wr && hit_opc && i_opc == 5'(i))
               opc_r[i] <= put_word(opc_r[i], d_opc[0], reg_wdata);
            // a preset replaces the count and counting goes on from it
            if (reg_wr && hit_pcnt && i_pcnt == 5'(i))
               pcnt_r[i] <= put_word(pcnt_r[i], d_pcnt[0], reg_wdata);
            if (reg_wr && hit_wt && i_wt == 5'(i))
               wt_r[i] <= reg_wdata;
            if (supply_lost)
            begin
               flow_r[i] <= '0;
               pend_r[i] <= 1'b0;
            end
         end
      end
   end

   // read path
   wire [15:0] lvl1_word = {5'h00, pin_now[CH_N-1:0]};
   wire [15:0] lvl2_word = {5'h00, pin_now[IN_N-1:CH_N]};
   wire [31:0] cons_val = 32'(pcnt_r[i_cons] * wt_r[i_cons]);
   wire [15:0] rd_word =
      hit_lvl1 ? lvl1_word :
      hit_lvl2 ? lvl2_word :
      hit_open ? {5'h00, open_r} & MAP_MASK :
      hit_close ? {5'h00, close_r} & MAP_MASK :
      hit_deact ? {5'h00, deact_r} & MAP_MASK :
      hit_act ? {5'h00, act_r} & MAP_MASK :
      hit_flow ? word_of(flow_r[i_flow], d_flow[0]) :
      hit_cons ? word_of(cons_val, d_cons[0]) :
      hit_opc ? word_of(opc_r[i_opc], d_opc[0]) :
      hit_pcnt ? word_of(pcnt_r[i_pcnt], d_pcnt[0]) :
      hit_wt ? wt_r[i_wt] : 16'h0000;
   wire rd_bad = !(hit_ro || hit_rw);
   wire wr_bad = !hit_rw;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         reg_rdata <= '0;
         reg_ack <= 1'b0;
         reg_err <= 1'b0;
      end
      else
      begin
         reg_ack <= reg_rd | reg_wr;
         reg_err <= (reg_rd && rd_bad) || (reg_wr && wr_bad);
         reg_rdata <= reg_rd ? rd_word : 16'h0000;
      end
   end
endmodule // cpio_regs

// File: dv/cpio_regs_properties.sv
// assertion checker bound to the channel pulse i/o register bank
`timescale 1ns/100ps
module cpio_regs_properties
   import cpio_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic reg_err,
   // field pins
   input wire logic [CH_N-1:0] first_input,
   input wire logic [CH_N-1:0] second_input,
   input wire logic [CH_N-1:0] product_present,
   input wire logic supply_fail,
   // order pulses
   input wire logic [CH_N-1:0] open_cmd,
   input wire logic [CH_N-1:0] close_cmd,
   input wire logic [CH_N-1:0] deactivate_cmd,
   input wire logic [CH_N-1:0] activate_cmd
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   a_ack_follows: assert property (
      (reg_rd || reg_wr) |=> reg_ack)
      else $error("no ack after strobe");
   a_level_ro: assert property (
      reg_wr && (reg_addr == A_LVL1 || reg_addr == A_LVL2) |=> reg_err)
      else $error("level map write not refused");
   a_map_unused: assert property (
      reg_rd && reg_addr >= A_OPEN && reg_addr <= A_ACT
      |=> reg_rdata[15:11] == 5'h00)
      else $error("unused order bits read nonzero");
   a_pair_exclusive: assert property (
      (open_cmd & close_cmd) == '0 && (deactivate_cmd & activate_cmd) == '0)
      else $error("opposite orders issued together");
   a_absent_quiet: assert property (
      !product_present[1] [*3]
      |=> !(open_cmd[1] || close_cmd[1] || deactivate_cmd[1]
      || activate_cmd[1]))
      else $error("order issued without product");
   a_open_pulse: assert property (
      reg_wr && reg_addr == A_OPEN && reg_wdata[0] && product_present[0]
      ##1 product_present[0] |-> ##[0:2] open_cmd[0])
      else $error("open order not issued");
   a_supply_clear: assert property (
      supply_fail [*6] ##0 (reg_rd && reg_addr == A_FLOW)
      |=> reg_rdata == 16'h0000)
      else $error("flow not cleared on supply loss");
   a_unmapped_err: assert property (
      reg_rd && reg_addr == 16'h0000 |=> reg_err && reg_rdata == 16'h0000)
      else $error("unmapped read not refused");
   a_order_write_ok: assert property (
      reg_wr && reg_addr == A_ACT |=> reg_ack && !reg_err)
      else $error("order map write refused");
endmodule // cpio_regs_properties

bind cpio_regs cpio_regs_properties #(.TICK_CYCLES(TICK_CYCLES))
   i_cpio_regs_properties (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
   .first_input(first_input), .second_input(second_input),
   .product_present(product_present), .supply_fail(supply_fail),
   .open_cmd(open_cmd), .close_cmd(close_cmd),
   .deactivate_cmd(deactivate_cmd), .activate_cmd(activate_cmd));

// File: dv/cpio_client.sv
// register client model driving the word port of the bank
`timescale 1ns/100ps
module cpio_client
(
   // clock
   input wire logic mclk,
   // request
   output logic [15:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [15:0] reg_wdata,
   // answer
   input wire logic [15:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic reg_err
);
   initial
   begin
      reg_addr = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
   end
   // one word per call; strobe is a single-cycle pulse, answer a cycle later
   task automatic xfer(input logic wr, input logic [15:0] a,
                       input logic [15:0] d, output logic [15:0] q,
                       output logic ack, output logic err);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = wr;
      reg_rd = !wr;
      @(negedge mclk);
      q = reg_rdata;
      ack = reg_ack;
      err = reg_err;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      // stale values are not left on the bus once released
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
endmodule // cpio_client

// File: dv/cpio_regs_tb.sv
// self-checking bench for the channel pulse i/o register bank
`timescale 1ns/100ps
module cpio_regs_tb
   import cpio_pkg::*;
;
   logic mclk, rst, reg_wr, reg_rd, reg_ack, reg_err, supply_fail, ack, err;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, q;
   logic [CH_N-1:0] first_input, second_input, product_present;
   logic [CH_N-1:0] open_cmd, close_cmd, deactivate_cmd, activate_cmd;
   logic [4*CH_N-1:0] seen;
   int err_count, cmp_count;

   // short ms tick keeps the five second wait inside the run
   cpio_regs #(.TICK_CYCLES(10)) i_cpio_regs (.mclk(mclk), .rst(rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .reg_err(reg_err), .first_input(first_input),
      .second_input(second_input), .product_present(product_present),
      .supply_fail(supply_fail), .open_cmd(open_cmd), .close_cmd(close_cmd),
      .deactivate_cmd(deactivate_cmd), .activate_cmd(activate_cmd));
   cpio_client i_cpio_client (.mclk(mclk), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err));

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [63:0] s, input logic [63:0] e,
                      input string m);
      cmp_count++;
      if (s !== e)
      begin
         err_count++;
         $display("[FAIL] %0t %s seen %h want %h", $time, m, s, e);
      end
   endtask

   task automatic rd(input logic [15:0] a, input logic [15:0] e,
                     input logic ee, input string m);
      i_cpio_client.xfer(1'b0, a, 16'h0000, q, ack, err);
      chk({ack, err, q}, {1'b1, ee, e}, m);
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d,
                     input logic ee, input string m);
      i_cpio_client.xfer(1'b1, a, d, q, ack, err);
      chk({ack, err}, {1'b1, ee}, m);
   endtask

   // pairs are high word first
   task automatic rd32(input logic [15:0] a, input logic [31:0] e,
                       input string m);
      rd(a, e[31:16], 1'b0, m);
      rd(a + 16'h0001, e[15:0], 1'b0, m);
   endtask

   // collect every order pulse over a few cycles
   task automatic grab;
      seen = '0;
      repeat (4)
      begin
         @(negedge mclk);
         seen = seen | {activate_cmd, deactivate_cmd, close_cmd, open_cmd};
      end
   endtask

   task automatic pulse(input int hi, input int lo);
      @(negedge mclk);
      first_input[0] = 1'b1;
      repeat (hi) @(negedge mclk);
      first_input[0] = 1'b0;
      repeat (lo) @(negedge mclk);
   endtask

   initial
   begin
      repeat (100000) @(posedge mclk);
      err_count++;
      wrap_up();
   end

   initial
   begin
      rst = 1'b1;
      supply_fail = 1'b0;
      first_input = '0;
      second_input = '0;
      product_present = '0;
      err_count = 0;
      cmp_count = 0;
      repeat (8) @(negedge mclk);
      rst = 1'b0;
      rd(A_LVL1, MAP_RST, 1'b0, "lvl1 rst");
      rd(A_LVL2, MAP_RST, 1'b0, "lvl2 rst");
      for (int k = 0; k < 4; k++)
         rd(A_OPEN + 16'(k), MAP_RST, 1'b0, "order rst");
      rd32(A_FLOW, CNT_RST, "flow rst");
      rd32(A_CONS + 16'h002a, CNT_RST, "cons rst");
      rd32(A_OPC, CNT_RST, "opc rst");
      rd(A_WT + 16'h0015, WT_RST, 1'b0, "weight rst");
      rd(16'h0000, 16'h0000, 1'b1, "unmapped rd");
      wr(A_LVL1, 16'hffff, 1'b1, "lvl1 wr");
      wr(A_FLOW, 16'hffff, 1'b1, "flow wr");
      rd(A_LVL1, 16'h0000, 1'b0, "lvl1 kept");
      $display("test reset done");
      product_present = '1;
      for (int k = 0; k < 4; k++)
      begin
         wr(A_OPEN + 16'(k), 16'hffff, 1'b0, "order wr");
         grab();
         chk(seen, 44'h7ff << (11 * k), "order pulses");
         rd(A_OPEN + 16'(k), 16'h0000, 1'b0, "order clr");
      end
      $display("test orders done");
      for (int k = 0; k < 4; k += 2)
      begin
         product_present[1] = 1'b0;
         wr(A_OPEN + 16'(k), 16'h0002, 1'b0, "pair a");
         wr(A_OPEN + 16'(k + 1), 16'h0002, 1'b0, "pair b");
         rd(A_OPEN + 16'(k), 16'h0002, 1'b0, "held");
         product_present[1] = 1'b1;
         grab();
         chk(seen, 44'h0, "pair quiet");
         rd(A_OPEN + 16'(k + 1), 16'h0000, 1'b0, "pair clr");
      end
      $display("test refusal done");
      // rises 1001 cycles apart span 100 tick edges, so exactly 100 ms
      // whatever the tick phase; 1000 apart could read 99 ms
      repeat (3) pulse(500, 500);
      rd32(A_FLOW, 32'h48afc800, "flow");
      rd32(A_CONS, 32'd30, "cons");
      rd32(A_OPC, 32'd3, "opc");
      supply_fail = 1'b1;
      repeat (6) @(negedge mclk);
      rd32(A_FLOW, 32'h0, "flow supply");
      supply_fail = 1'b0;
      wr(A_PCNT, 16'h0000, 1'b0, "pcnt hi");
      wr(A_PCNT + 16'h0001, 16'h0064, 1'b0, "pcnt lo");
      wr(A_WT, 16'h0014, 1'b0, "weight");
      wr(A_OPC + 16'h0001, 16'h0007, 1'b0, "opc wr");
      pulse(20, 20);
      rd32(A_CONS, 32'd2020, "cons preset");
      rd32(A_OPC, 32'd8, "opc preset");
      repeat (51000) @(negedge mclk);
      rd32(A_FLOW, 32'h0, "flow idle");
      $display("test pulses done");
      first_input = 11'h555;
      second_input = 11'h2aa;
      repeat (4) @(negedge mclk);
      rd(A_LVL1, 16'h0555, 1'b0, "lvl1");
      rd(A_LVL2, 16'h02aa, 1'b0, "lvl2");
      $display("test levels done");
      wrap_up();
   end
endmodule // cpio_regs_tb
